/* prm_rotation.sv */
// Purpose: pump rotation manager, level switches in, pump drives out
// Assumes: inputs synchronous to i_sys_clk, one scan per scan tick
// Notes:   level and limit inputs are sampled only on the scan tick, program init and power loss act in any cycle
//
// Contract
// - running pump count equals ON input count, capped by limit and four.
// - on a rise, pumps start in ascending circular order from the index.
// - on a fall, the longest continuously running pumps stop first.
// - after a stop, the index moves to the pump after those stopped.
// - the current index is visible on an integer output.
// - the limit accepts only two, three or four.
// - limit two uses pumps one and two only, three and four stay off.
// - limit three uses pumps one to three, pump four stays off.
// - limit four lets all four pumps rotate.
// - an unconnected level input counts as OFF.
// - program initialisation loads the index with one.
// - with the option set, power loss restores index one, else keeps it.
`timescale 1ns/1ps
`include "prm_regs.svh"

module prm_rotation (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic [3:0] i_level,
	input  wire logic [3:0] i_level_conn,
	input  wire logic [2:0] i_limit,
	input  wire logic       i_prog_init,
	input  wire logic       i_power_restored,
	input  wire logic       i_reset_on_loss,
	output logic [3:0]      o_pump,
	output logic [2:0]      o_next_output_index,
	output logic [2:0]      o_limit,
	output logic            o_scan_tick
);

	localparam logic [`PRM_SCAN_CNT_W-1:0] SCAN_LAST =
		`PRM_SCAN_CNT_W'(`PRM_SCAN_CYCLES - 1);

	logic [`PRM_SCAN_CNT_W-1:0] scan_cnt_reg;
	logic [`PRM_SCAN_CNT_W-1:0] scan_cnt_next;
	logic                       scan_tick;
	logic [3:0]                 pump_reg;
	prm_pkg::prm_age_t          age_reg;
	prm_pkg::prm_idx_t          idx_reg;
	prm_pkg::prm_idx_t          idx_next;
	prm_pkg::prm_cnt_t          limit_reg;
	prm_pkg::prm_cnt_t          limit_use;
	logic [3:0]                 level_on;
	prm_pkg::prm_cnt_t          level_cnt;
	prm_pkg::prm_cnt_t          target;
	logic                       loss_reset;
	logic [3:0]                 pump_in_lim;
	logic [3:0]                 stop_mask;
	logic                       stop_one;
	prm_pkg::prm_idx_t          stop_num;
	logic                       stop_oldest;
	logic [3:0][7:0]            run_reg;
	logic [3:0][7:0]            run_next;

	// 1-based number of the lowest pump bit set, zero when none is set
	function automatic prm_pkg::prm_idx_t prm_pump_num(input logic [3:0] v);
		prm_pkg::prm_idx_t num;
		num = 3'h0;
		for (int i = 3; i >= 0; i--) begin
			if (v[i]) begin
				num = prm_pkg::prm_idx_t'(i + 1);
			end
		end
		return num;
	endfunction : prm_pump_num

	prm_step_if step ();

	// scan tick divider
	assign scan_tick     = (scan_cnt_reg == SCAN_LAST);
	assign scan_cnt_next = scan_tick ? '0 : scan_cnt_reg + `PRM_SCAN_CNT_W'(1);

	// wanted pump count
	assign level_on   = i_level & i_level_conn;
	assign level_cnt  = prm_pkg::prm_pop(level_on);
	assign limit_use  = prm_pkg::prm_lim_ok(i_limit) ? i_limit : limit_reg;
	assign target     = (level_cnt > limit_use) ? limit_use : level_cnt;
	assign loss_reset = i_power_restored && i_reset_on_loss;

	// step engine inputs
	assign step.idx     = idx_reg;
	assign step.limit   = limit_use;
	assign step.target  = target;
	assign step.on_mask = pump_reg;
	assign step.age     = age_reg;

	prm_step_eng u_eng (
		.st (step.eng)
	);

	// index source: init and power loss win over the scan result
	always_comb begin
		idx_next = idx_reg;
		if (i_prog_init) begin
			idx_next = `PRM_IDX_INIT;
		end else if (loss_reset) begin
			idx_next = `PRM_IDX_INIT;
		end else if (scan_tick) begin
			idx_next = step.idx_next;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scan_cnt_reg <= '0;
		end else begin
			scan_cnt_reg <= scan_cnt_next;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx_reg <= `PRM_IDX_INIT;
		end else begin
			idx_reg <= idx_next;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			limit_reg <= `PRM_LIMIT_RST;
		end else if (scan_tick) begin
			limit_reg <= limit_use;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pump_reg <= 4'h0;
			age_reg  <= '0;
		end else if (i_prog_init) begin
			pump_reg <= 4'h0;
			age_reg  <= '0;
		end else if (scan_tick) begin
			pump_reg <= step.on_next;
			age_reg  <= step.age_next;
		end
	end

	assign o_pump              = pump_reg;
	assign o_next_output_index = idx_reg;
	assign o_limit             = limit_reg;
	assign o_scan_tick         = scan_tick;

	// run time of each pump in scans, saturating, kept only for the checks below
	assign pump_in_lim = pump_reg & prm_pkg::prm_lim_mask(limit_use);
	assign stop_mask   = (scan_tick && !i_prog_init) ? pump_in_lim & ~step.on_next : 4'h0;
	assign stop_one    = (stop_mask != 4'h0) && ((stop_mask & (stop_mask - 4'h1)) == 4'h0);
	assign stop_num    = prm_pump_num(stop_mask);

	// a pump that goes off starts again from zero
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			run_next[i] = run_reg[i];
			if (!step.on_next[i]) begin
				run_next[i] = 8'h00;
			end else if (run_reg[i] != 8'hff) begin
				run_next[i] = run_reg[i] + 8'h01;
			end
		end
	end

	// a stopping pump must have run at least as long as every pump kept on
	always_comb begin
		stop_oldest = 1'b1;
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 4; j++) begin
				if (stop_mask[i] && pump_reg[j] && step.on_next[j]
					&& run_reg[i] < run_reg[j]) begin
					stop_oldest = 1'b0;
				end
			end
		end
	end

	// cleared with the pumps on program init
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_reg <= '0;
		end else if (i_prog_init) begin
			run_reg <= '0;
		end else if (scan_tick) begin
			run_reg <= run_next;
		end
	end

	// checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	pump_count_a: assert property (
		scan_tick && !i_prog_init |=>
			prm_pkg::prm_pop(o_pump) == $past(target))
		else $error("running pump count differs from clipped input count");

	limit_legal_a: assert property (
		o_limit >= `PRM_LIMIT_MIN && o_limit <= `PRM_LIMIT_MAX)
		else $error("pump limit outside two to four");

	limit_two_a: assert property (
		o_limit == 3'h2 |-> o_pump[3:2] == 2'h0)
		else $error("pump three or four on under limit two");

	limit_three_a: assert property (
		o_limit == 3'h3 |-> !o_pump[3])
		else $error("pump four on under limit three");

	limit_four_a: assert property (
		scan_tick && !i_prog_init && limit_use == 3'h4 && level_cnt == 3'h4
			|=> o_pump == 4'hf)
		else $error("all four pumps not running under limit four");

	init_index_a: assert property (
		i_prog_init |=> o_next_output_index == `PRM_IDX_INIT && o_pump == 4'h0)
		else $error("program init did not load index one");

	loss_index_a: assert property (
		loss_reset |=> o_next_output_index == `PRM_IDX_INIT)
		else $error("power loss option did not restore index one");

	loss_keep_a: assert property (
		i_power_restored && !i_reset_on_loss && !i_prog_init && !scan_tick
			|=> $stable(o_next_output_index))
		else $error("index changed on power loss with option clear");

	index_range_a: assert property (
		scan_tick && !i_prog_init && !loss_reset |=>
			o_next_output_index >= 3'h1 && o_next_output_index <= o_limit)
		else $error("index outside one to limit after scan");

	index_hold_a: assert property (
		scan_tick && !i_prog_init && !loss_reset && limit_use == limit_reg
			&& idx_reg <= limit_reg && (pump_reg & ~step.on_next) == 4'h0
			|=> $stable(o_next_output_index))
		else $error("index moved without any pump stopping");

	rise_order_a: assert property (
		scan_tick && !i_prog_init && pump_reg == 4'h0 && target != 3'h0
			&& idx_reg <= limit_use
			|=> o_pump[prm_pkg::prm_bit($past(idx_reg))])
		else $error("first started pump is not the indexed one");

	scan_only_a: assert property (
		!scan_tick && !i_prog_init |=> $stable(o_pump))
		else $error("pump outputs changed between scans");

	tick_spacing_a: assert property (
		scan_tick |=> !scan_tick)
		else $error("scan ticks back to back");

	oldest_stop_a: assert property (
		scan_tick && !i_prog_init |-> stop_oldest)
		else $error("a pump stopped before an older running pump");

	stop_index_a: assert property (
		stop_one && !loss_reset |=>
			o_next_output_index == prm_pkg::prm_next($past(stop_num), o_limit))
		else $error("index does not follow the stopped pump");

	index_bound_a: assert property (
		o_next_output_index != 3'h0 && o_next_output_index <= 3'h4)
		else $error("index output outside one to four");

	pump_cap_a: assert property (
		prm_pkg::prm_pop(o_pump) <= o_limit)
		else $error("more pumps running than the limit allows");

	limit_hold_a: assert property (
		scan_tick && !prm_pkg::prm_lim_ok(i_limit) |=> $stable(o_limit))
		else $error("illegal limit value was taken");

	float_off_a: assert property (
		scan_tick && !i_prog_init |=>
			prm_pkg::prm_pop(o_pump) <= prm_pkg::prm_pop($past(i_level_conn)))
		else $error("pump count exceeds the connected inputs");

	rise_keep_a: assert property (
		scan_tick && !i_prog_init && target >= prm_pkg::prm_pop(pump_in_lim)
			|=> (o_pump & $past(pump_in_lim)) == $past(pump_in_lim))
		else $error("a running pump stopped while demand rose");

	fall_keep_a: assert property (
		scan_tick && !i_prog_init && target <= prm_pkg::prm_pop(pump_in_lim)
			|=> (o_pump & ~$past(pump_in_lim)) == 4'h0)
		else $error("a pump started while demand fell");

	loss_pump_a: assert property (
		loss_reset && !i_prog_init && !scan_tick |=> $stable(o_pump))
		else $error("power loss restore changed the pumps");

	idle_index_a: assert property (
		!scan_tick && !i_prog_init && !loss_reset |=> $stable(o_next_output_index))
		else $error("index changed between scans");

endmodule : prm_rotation

/* prm_regs.svh */
// Purpose: constants of the pump rotation manager
// Assumes: 125 MHz system clock
// Notes:   index values are 1-based, 1 selects pump output 1
`ifndef PRM_REGS_SVH
`define PRM_REGS_SVH

// number of pump outputs and level inputs
`define PRM_NUM_PUMPS      4
// next-output index after program init or power loss
`define PRM_IDX_INIT       3'h1
// output limit after reset, and the legal limit values
`define PRM_LIMIT_RST      3'h4
`define PRM_LIMIT_MIN      3'h2
`define PRM_LIMIT_MAX      3'h4
// scan period in ns, clock period in ns, and scan period in clock cycles
`define PRM_SCAN_PERIOD_NS 1000
`define PRM_CLK_PERIOD_NS  8
`define PRM_SCAN_CYCLES    (`PRM_SCAN_PERIOD_NS / `PRM_CLK_PERIOD_NS)
`define PRM_SCAN_CNT_W     7

`endif

/* prm_pkg.sv */
// Purpose: types and shared arithmetic of the pump rotation manager
// Assumes: four pumps, 1-based index
// Notes:   functions are shared by the scan control and the step engine
`include "prm_regs.svh"

package prm_pkg;

	typedef logic [2:0]      prm_idx_t;
	typedef logic [2:0]      prm_cnt_t;
	typedef logic [3:0][1:0] prm_age_t;

	// number of set bits
	function automatic prm_cnt_t prm_pop(input logic [3:0] v);
		prm_cnt_t c;
		c = 3'h0;
		for (int i = 0; i < 4; i++) begin
			c = c + {2'h0, v[i]};
		end
		return c;
	endfunction : prm_pop

	// pumps usable under a limit
	function automatic logic [3:0] prm_lim_mask(input prm_cnt_t lim);
		logic [3:0] m;
		unique case (lim)
			3'h2:    m = 4'h3;
			3'h3:    m = 4'h7;
			default: m = 4'hf;
		endcase
		return m;
	endfunction : prm_lim_mask

	// index following x, wrapping after the limit back to 1
	function automatic prm_idx_t prm_next(input prm_idx_t x, input prm_cnt_t lim);
		return (x >= lim) ? `PRM_IDX_INIT : prm_idx_t'(x + 3'h1);
	endfunction : prm_next

	// bring an index into 1..limit
	function automatic prm_idx_t prm_wrap(input prm_idx_t x, input prm_cnt_t lim);
		return (x == 3'h0 || x > lim) ? `PRM_IDX_INIT : x;
	endfunction : prm_wrap

	// bit position of a 1-based index
	function automatic logic [1:0] prm_bit(input prm_idx_t x);
		return x[1:0] - 2'h1;
	endfunction : prm_bit

	// is the limit one of the accepted values
	function automatic logic prm_lim_ok(input prm_cnt_t lim);
		return lim >= `PRM_LIMIT_MIN && lim <= `PRM_LIMIT_MAX;
	endfunction : prm_lim_ok

endpackage : prm_pkg

/* prm_step_if.sv */
// Purpose: carries rotation state to the step engine and the result back
// Assumes: one scan evaluation per use
// Notes:   ctl drives the present state, eng returns the next state
`timescale 1ns/1ps

interface prm_step_if;
	prm_pkg::prm_idx_t idx;
	prm_pkg::prm_cnt_t limit;
	prm_pkg::prm_cnt_t target;
	logic [3:0]        on_mask;
	prm_pkg::prm_age_t age;
	prm_pkg::prm_idx_t idx_next;
	logic [3:0]        on_next;
	prm_pkg::prm_age_t age_next;

	modport ctl (output idx, limit, target, on_mask, age,
	             input  idx_next, on_next, age_next);
	modport eng (input  idx, limit, target, on_mask, age,
	             output idx_next, on_next, age_next);
endinterface : prm_step_if

/* prm_step_eng.sv */
// Purpose: applies every switch-on or switch-off step of one scan
// Assumes: limit already legal, target already clipped to the limit
// Notes:   age 0 is the pump that has been on longest
`timescale 1ns/1ps

module prm_step_eng (
	prm_step_if.eng st
);

	logic [3:0]        m;
	prm_pkg::prm_age_t a;
	prm_pkg::prm_idx_t ix;
	prm_pkg::prm_idx_t p;
	prm_pkg::prm_cnt_t cnt;
	logic              done;

	always_comb begin
		m    = st.on_mask & prm_pkg::prm_lim_mask(st.limit);
		a    = '0;
		ix   = prm_pkg::prm_wrap(st.idx, st.limit);
		p    = ix;
		cnt  = 3'h0;
		done = 1'b0;
		// compact ages of the pumps still allowed
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 4; j++) begin
				if (m[i] && m[j] && st.age[j] < st.age[i]) begin
					a[i] = a[i] + 2'h1;
				end
			end
		end
		// one step per unit of difference between running and wanted
		for (int s = 0; s < 4; s++) begin
			cnt  = prm_pkg::prm_pop(m);
			done = 1'b0;
			if (cnt < st.target) begin
				// first idle pump in ascending circular order from the index
				p = ix;
				for (int k = 0; k < 4; k++) begin
					if (!done && !m[prm_pkg::prm_bit(p)]) begin
						m[prm_pkg::prm_bit(p)] = 1'b1;
						a[prm_pkg::prm_bit(p)] = cnt[1:0];
						done                   = 1'b1;
					end
					p = prm_pkg::prm_next(p, st.limit);
				end
			end else if (cnt > st.target) begin
				// oldest running pump goes off, index moves past it
				for (int j = 0; j < 4; j++) begin
					if (!done && m[j] && a[j] == 2'h0) begin
						m[j] = 1'b0;
						ix   = prm_pkg::prm_next(prm_pkg::prm_idx_t'(j + 1), st.limit);
						done = 1'b1;
					end
				end
				for (int j = 0; j < 4; j++) begin
					if (m[j]) begin
						a[j] = a[j] - 2'h1;
					end
				end
			end
		end
		st.on_next  = m;
		st.age_next = a;
		st.idx_next = ix;
	end

endmodule : prm_step_eng

/* prm_tank_model.sv */
// Purpose: level switch side of the pump rotation manager
// Assumes: bench changes the wanted pattern at the falling edge
// Notes:   unconnected lines carry a toggling pattern, never a clean OFF
`timescale 1ns/1ps

module prm_tank_model (
	input  wire logic       i_sys_clk,
	input  wire logic [3:0] i_want_level,
	input  wire logic [3:0] i_want_conn,
	output logic [3:0]      o_level,
	output logic [3:0]      o_conn
);
	logic flip_reg = 1'b0;

	always_ff @(negedge i_sys_clk) begin
		flip_reg <= ~flip_reg;
	end

	// a floating switch line is not trusted to read OFF
	assign o_conn  = i_want_conn;
	assign o_level = (i_want_level & i_want_conn) | (~i_want_conn & {4{flip_reg}});
endmodule : prm_tank_model

/* prm_rotation_tb.sv */
// Purpose: self-checking bench of the pump rotation manager
// Assumes: 125 MHz clock, 125 cycles per scan
// Notes:   rows give inputs and the pumps, index and limit after one scan
`timescale 1ns/1ps

module prm_rotation_tb;
	typedef struct packed {
		logic       init;
		logic [3:0] lvl;
		logic [3:0] conn;
		logic [2:0] lim;
		logic [3:0] pump;
		logic [2:0] idx;
		logic [2:0] olim;
	} prm_row_t;

	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [3:0] want_lvl = 4'h0;
	logic [3:0] want_conn = 4'hf;
	logic [3:0] level;
	logic [3:0] conn;
	logic [2:0] limit = 3'h4;
	logic       init = 1'b0;
	logic       pwr = 1'b0;
	logic       opt = 1'b0;
	logic [3:0] pump;
	logic [2:0] idx;
	logic [2:0] olim;
	logic       tick;
	int         mismatches = 0;
	int         compares = 0;
	int         n;
	prm_row_t   rows [16] = '{
		{1'b0, 4'h3, 4'hf, 3'h4, 4'h3, 3'h1, 3'h4}, {1'b0, 4'h1, 4'hf, 3'h4, 4'h2, 3'h2, 3'h4},
		{1'b0, 4'h3, 4'hf, 3'h4, 4'h6, 3'h2, 3'h4}, {1'b0, 4'h1, 4'hf, 3'h4, 4'h4, 3'h3, 3'h4},
		{1'b0, 4'h0, 4'hf, 3'h4, 4'h0, 3'h4, 3'h4}, {1'b0, 4'hf, 4'hf, 3'h4, 4'hf, 3'h4, 3'h4},
		{1'b0, 4'h3, 4'hf, 3'h4, 4'h6, 3'h2, 3'h4}, {1'b0, 4'hf, 4'h1, 3'h4, 4'h4, 3'h3, 3'h4},
		{1'b1, 4'hf, 4'hf, 3'h2, 4'h3, 3'h1, 3'h2}, {1'b0, 4'h7, 4'hf, 3'h2, 4'h3, 3'h1, 3'h2},
		{1'b0, 4'h1, 4'hf, 3'h2, 4'h2, 3'h2, 3'h2}, {1'b0, 4'h3, 4'hf, 3'h2, 4'h3, 3'h2, 3'h2},
		{1'b0, 4'hf, 4'hf, 3'h3, 4'h7, 3'h2, 3'h3}, {1'b0, 4'h0, 4'hf, 3'h3, 4'h0, 3'h1, 3'h3},
		{1'b0, 4'h3, 4'hf, 3'h5, 4'h3, 3'h1, 3'h3}, {1'b0, 4'h1, 4'hf, 3'h0, 4'h2, 3'h2, 3'h3}
	};

	initial begin
		forever #4 clk = ~clk;
	end

	prm_tank_model i_tank (
		.i_sys_clk    (clk),
		.i_want_level (want_lvl),
		.i_want_conn  (want_conn),
		.o_level      (level),
		.o_conn       (conn)
	);

	prm_rotation i_dut (
		.i_sys_clk           (clk),
		.i_rst_n             (rst_n),
		.i_level             (level),
		.i_level_conn        (conn),
		.i_limit             (limit),
		.i_prog_init         (init),
		.i_power_restored    (pwr),
		.i_reset_on_loss     (opt),
		.o_pump              (pump),
		.o_next_output_index (idx),
		.o_limit             (olim),
		.o_scan_tick         (tick)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	// returns at the falling edge just after a scan was taken
	task automatic wait_scan();
		n = 0;
		while (tick !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (tick !== 1'b1) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, tick, 1'b1);
		end
		@(negedge clk);
	endtask : wait_scan

	task automatic chk_out(input logic [3:0] p, input logic [2:0] i, input logic [2:0] l);
		chk({4'h0, pump}, {4'h0, p});
		chk({5'h0, idx}, {5'h0, i});
		chk({5'h0, olim}, {5'h0, l});
	endtask : chk_out

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end

	initial begin
		repeat (12) @(negedge clk);
		chk_out(4'h0, 3'h1, 3'h4);
		rst_n = 1'b1;
		foreach (rows[r]) begin
			@(negedge clk);
			want_lvl = rows[r].lvl;
			want_conn = rows[r].conn;
			limit = rows[r].lim;
			init = rows[r].init;
			@(negedge clk);
			init = 1'b0;
			wait_scan();
			chk_out(rows[r].pump, rows[r].idx, rows[r].olim);
		end
		pwr = 1'b1;
		@(negedge clk);
		pwr = 1'b0;
		@(negedge clk);
		chk_out(4'h2, 3'h2, 3'h3);
		opt = 1'b1;
		pwr = 1'b1;
		@(negedge clk);
		pwr = 1'b0;
		@(negedge clk);
		chk_out(4'h2, 3'h1, 3'h3);
		wait_scan();
		n = 1;
		while (tick !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n), 8'h7d);
		rst_n = 1'b0;
		@(negedge clk);
		chk_out(4'h0, 3'h1, 3'h4);
		chk({7'h0, tick}, 8'h00);
		want_lvl = 4'hf;
		limit = 3'h4;
		rst_n = 1'b1;
		n = 1;
		while (tick !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n), 8'h7d);
		@(negedge clk);
		chk_out(4'hf, 3'h1, 3'h4);
		limit = 3'h2;
		wait_scan();
		chk_out(4'h3, 3'h1, 3'h2);
		end_of_test();
	end
endmodule : prm_rotation_tb
